// File: src/nsf_consts.svh
`ifndef NSF_CONSTS_SVH
`define NSF_CONSTS_SVH
// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define NSF_ADDR_W      40
`define NSF_LINE_BYTES  64
`define NSF_CHUNK_BYTES 16
`define NSF_LINE_OFS_W  6
`define NSF_CHUNK_OFS_W 4
// ----------------------------------------------------------------
// Memory type codes
// ----------------------------------------------------------------
`define NSF_MT_UC 3'h0
`define NSF_MT_WC 3'h1
`define NSF_MT_WT 3'h4
`define NSF_MT_WP 3'h5
`define NSF_MT_WB 3'h6
// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define NSF_OP_NT_STORE     3'h0
`define NSF_OP_NT_PACKED_SG 3'h1
`define NSF_OP_NT_MASKED    3'h2
`define NSF_OP_STORE_FENCE  3'h3
`define NSF_OP_LOAD_FENCE   3'h4
`define NSF_OP_FULL_FENCE   3'h5
`endif

// File: src/nsf_pkg.sv
`include "nsf_consts.svh"
package nsf_pkg;
    localparam int LINE_ADDR_W = `NSF_ADDR_W - `NSF_LINE_OFS_W;

    typedef enum logic [2:0] {
        MT_UNCACHEABLE     = `NSF_MT_UC,
        MT_WRITE_COMBINING = `NSF_MT_WC,
        MT_WRITE_THROUGH   = `NSF_MT_WT,
        MT_WRITE_PROTECT   = `NSF_MT_WP,
        MT_WRITE_BACK      = `NSF_MT_WB
    } nsf_mtype_e;

    typedef enum logic [2:0] {
        OP_NT_STORE               = `NSF_OP_NT_STORE,
        OP_NT_STORE_PACKED_SINGLE = `NSF_OP_NT_PACKED_SG,
        OP_NT_MASKED_STORE        = `NSF_OP_NT_MASKED,
        OP_STORE_FENCE            = `NSF_OP_STORE_FENCE,
        OP_LOAD_FENCE             = `NSF_OP_LOAD_FENCE,
        OP_FULL_FENCE             = `NSF_OP_FULL_FENCE
    } nsf_op_e;

    typedef enum logic [1:0] {
        PATH_UNCACHED = 2'h0,
        PATH_COMBINE  = 2'h1,
        PATH_IN_PLACE = 2'h2,
        PATH_FAULT    = 2'h3
    } nsf_path_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_BUS   = 2'h2,
        ST_FENCE = 2'h3
    } nsf_state_e;

    typedef struct packed {
        nsf_op_e                     op;
        nsf_mtype_e                  mtype;
        logic [`NSF_ADDR_W-1:0]      addr;
        logic [8*`NSF_CHUNK_BYTES-1:0] data;
        logic [`NSF_CHUNK_BYTES-1:0] be;
        logic [8*`NSF_CHUNK_BYTES-1:0] mask;
        logic                        l1_hit;
        logic                        l2_hit;
    } nsf_req_s;

    typedef struct packed {
        logic                         valid;
        logic [LINE_ADDR_W-1:0]       addr;
        logic [8*`NSF_LINE_BYTES-1:0] data;
        logic [`NSF_LINE_BYTES-1:0]   be;
        nsf_mtype_e                   mtype;
    } nsf_line_s;

    typedef struct packed {
        nsf_path_e                    path;
        logic                         fence;
        logic                         evict;
        logic [LINE_ADDR_W-1:0]       addr;
        logic [8*`NSF_LINE_BYTES-1:0] data;
        logic [`NSF_LINE_BYTES-1:0]   be;
    } nsf_dec_s;

    typedef struct packed {
        nsf_state_e             st;
        nsf_req_s               req;
        logic                   pend;
        logic                   drain;
        logic                   flush;
        logic                   ready;
        nsf_line_s              bus;
        nsf_line_s              l1;
        logic                   evict_v;
        logic [LINE_ADDR_W-1:0] evict_addr;
        logic                   fault;
        logic                   fence_done;
        logic                   hold_loads;
    } nsf_top_state_s;
endpackage : nsf_pkg

// File: src/nsf_req_decode.sv
`timescale 1ns/100ps
`default_nettype none
module nsf_req_decode
    import nsf_pkg::*;
(
    input  wire nsf_req_s req,
    output nsf_dec_s      dec
);
    // ----------------------------------------------------------------
    // Classify one request and place its chunk in a line
    // ----------------------------------------------------------------
    logic [`NSF_CHUNK_BYTES-1:0] be16;
    logic                        cacheable;

    always_comb begin
        // Masked store keeps a byte only when its mask byte has the top bit set
        for (int i = 0; i < `NSF_CHUNK_BYTES; i++) begin
            be16[i] = req.be[i] & ((req.op != OP_NT_MASKED_STORE) | req.mask[8*i+7]);
        end
        cacheable = (req.mtype == MT_WRITE_BACK) || (req.mtype == MT_WRITE_THROUGH);
        dec.fence = (req.op == OP_STORE_FENCE) || (req.op == OP_LOAD_FENCE) || (req.op == OP_FULL_FENCE);
        dec.addr  = req.addr[`NSF_ADDR_W-1:`NSF_LINE_OFS_W];
        dec.data  = {4{req.data}};
        dec.be    = {48'h0, be16} << {req.addr[5:4], 4'h0};
        dec.evict = cacheable && !req.l1_hit && req.l2_hit;
        // Misaligned packed single faults before any path is chosen
        if (req.op == OP_NT_STORE_PACKED_SINGLE && req.addr[`NSF_CHUNK_OFS_W-1:0] != 4'h0) begin
            dec.path = PATH_FAULT;
        end else if (cacheable && req.l1_hit) begin
            dec.path = PATH_IN_PLACE;
        end else if (cacheable || req.mtype == MT_WRITE_COMBINING) begin
            dec.path = PATH_COMBINE;
        end else begin
            dec.path = PATH_UNCACHED;
        end
    end
endmodule : nsf_req_decode
`default_nettype wire

// File: src/nsf_wc_buffer.sv
`timescale 1ns/100ps
`default_nettype none
module nsf_wc_buffer
    import nsf_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         merge,
    input  wire logic [LINE_ADDR_W-1:0]       merge_addr,
    input  wire logic [8*`NSF_LINE_BYTES-1:0] merge_data,
    input  wire logic [`NSF_LINE_BYTES-1:0]   merge_be,
    input  wire nsf_mtype_e                   merge_mtype,
    input  wire logic                         clear,
    output nsf_line_s                         line
);
    // ----------------------------------------------------------------
    // One combining line: address, data and per-byte valid mask
    // ----------------------------------------------------------------
    nsf_line_s r, n;

    // Caller merges only into an empty buffer or the same line
    always_comb begin
        n = r;
        if (clear) begin
            n.valid = 1'b0;
            n.be    = '0;
        end
        if (merge) begin
            if (!n.valid) begin
                n.addr  = merge_addr;
                n.mtype = merge_mtype; // Type of first store wins
            end
            n.valid = 1'b1;
            for (int i = 0; i < `NSF_LINE_BYTES; i++) begin
                if (merge_be[i]) begin
                    n.data[8*i +: 8] = merge_data[8*i +: 8]; // Newest byte overwrites
                    n.be[i]          = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign line = r;
endmodule : nsf_wc_buffer
`default_nettype wire

// File: src/nsf_unit.sv
// Contract
// - Same-line non-temporal stores merge into one line
// - Overlapping bytes keep only the newest value
// - Combined writes leave in any order
// - No cache allocation, never read for ownership
// - Fully written line goes out as one write
// - Uncacheable or protected region: plain uncached store
// - Write-combining region keeps its own semantics
// - Cached hit keeps data consistent
// - First-level hit merges bytes in place
// - Second-level hit writes line and data out
// - Cacheable miss combines, weakly ordered, no allocate
// - Combined data leaves only guaranteed after fence
// - Misaligned packed single raises protection fault
// - Masked store writes bytes whose mask top set
// - Store fence holds later stores until visible
// - Load fence holds later loads until visible
// - Full fence holds loads and stores
// - Load and store fences not mutually ordered
// - Write-back regions accept non-temporal stores
// - Bus type taken from first store
`timescale 1ns/100ps
`default_nettype none
module nsf_unit
    import nsf_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           req_valid,
    input  wire nsf_req_s       req,
    output logic                req_ready,
    input  wire logic           sq_empty,
    input  wire logic           lq_empty,
    output nsf_line_s           bus_wr,
    input  wire logic           bus_ack,
    output nsf_line_s           l1_upd,
    output logic                l2_evict_valid,
    output logic [LINE_ADDR_W-1:0] l2_evict_addr,
    output logic                nt_fault,
    output logic                fence_done,
    output logic                hold_loads
);
    // ----------------------------------------------------------------
    // Sub-blocks
    // ----------------------------------------------------------------
    nsf_top_state_s r, n;
    nsf_dec_s       dec;
    nsf_line_s      buf_line;
    logic           buf_merge;
    logic           buf_clear;
    logic           same_line;
    logic           need_st;
    logic           need_ld;

    nsf_req_decode u_dec (
        .req (r.req),
        .dec (dec)
    );

    nsf_wc_buffer u_buf (
        .clk         (clk),
        .rst_n       (rst_n),
        .merge       (buf_merge),
        .merge_addr  (dec.addr),
        .merge_data  (dec.data),
        .merge_be    (dec.be),
        .merge_mtype (r.req.mtype),
        .clear       (buf_clear),
        .line        (buf_line)
    );

    // ----------------------------------------------------------------
    // Control
    // ----------------------------------------------------------------
    assign same_line = !buf_line.valid || (buf_line.addr == dec.addr);
    assign need_st   = (r.req.op != OP_LOAD_FENCE);
    assign need_ld   = (r.req.op != OP_STORE_FENCE);

    // Next state; pulses default low each cycle
    always_comb begin
        n            = r;
        n.l1.valid   = 1'b0;
        n.evict_v    = 1'b0;
        n.fault      = 1'b0;
        n.fence_done = 1'b0;
        buf_merge    = 1'b0;
        buf_clear    = 1'b0;
        unique case (r.st)
            ST_IDLE: begin
                // Full or evicted line is pushed before new work is taken
                if (r.flush) begin
                    n.bus       = buf_line; // One write for a whole line
                    n.bus.valid = 1'b1;
                    n.drain     = 1'b1;
                    n.pend      = 1'b0;
                    n.flush     = 1'b0;
                    n.st        = ST_BUS;
                end else if (req_valid && r.ready) begin
                    n.req = req;
                    n.st  = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (dec.fence) begin
                    n.hold_loads = need_ld; // Store fence leaves loads free
                    n.st         = ST_FENCE;
                end else begin
                    unique case (dec.path)
                        PATH_FAULT: begin
                            n.fault = 1'b1; // Nothing stored
                            n.st    = ST_IDLE;
                        end
                        PATH_UNCACHED: begin
                            n.bus.valid = 1'b1; // Hint dropped, region type kept
                            n.bus.addr  = dec.addr;
                            n.bus.data  = dec.data;
                            n.bus.be    = dec.be;
                            n.bus.mtype = r.req.mtype;
                            n.drain     = 1'b0;
                            n.pend      = 1'b0;
                            n.st        = ST_BUS;
                        end
                        PATH_IN_PLACE: begin
                            n.l1.valid = 1'b1; // Update in first-level line
                            n.l1.addr  = dec.addr;
                            n.l1.data  = dec.data;
                            n.l1.be    = dec.be;
                            n.l1.mtype = r.req.mtype;
                            n.st       = ST_IDLE;
                        end
                        PATH_COMBINE: begin
                            if (!same_line) begin
                                // Other line pending: drain it, then retry this store
                                n.bus       = buf_line;
                                n.bus.valid = 1'b1;
                                n.drain     = 1'b1;
                                n.pend      = 1'b1;
                                n.st        = ST_BUS;
                            end else begin
                                buf_merge    = 1'b1;
                                n.evict_v    = dec.evict;
                                n.evict_addr = dec.addr;
                                n.flush      = dec.evict || (&(buf_line.be | dec.be));
                                n.st         = ST_IDLE;
                            end
                        end
                    endcase
                end
            end
            ST_BUS: begin
                // Write only: the bus never sees a read for this line
                if (bus_ack) begin
                    n.bus.valid = 1'b0;
                    buf_clear   = r.drain;
                    n.st        = r.pend ? ST_EXEC : ST_IDLE;
                    n.pend      = 1'b0;
                end
            end
            ST_FENCE: begin
                if (need_st && buf_line.valid) begin
                    n.bus       = buf_line; // Store or full fence forces pending line out
                    n.bus.valid = 1'b1;
                    n.drain     = 1'b1;
                    n.pend      = 1'b1;
                    n.st        = ST_BUS;
                end else if ((!need_st || sq_empty) && (!need_ld || lq_empty)) begin
                    n.fence_done = 1'b1;
                    n.hold_loads = 1'b0;
                    n.st         = ST_IDLE;
                end
            end
        endcase
        // Ready only when idle with nothing to push; stalls all later ops
        n.ready = (n.st == ST_IDLE) && !n.flush;
    end

    // Drain order is free relative to other traffic; no ordering beyond fences
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign req_ready      = r.ready;
    assign bus_wr         = r.bus;
    assign l1_upd         = r.l1;
    assign l2_evict_valid = r.evict_v;
    assign l2_evict_addr  = r.evict_addr;
    assign nt_fault       = r.fault;
    assign fence_done     = r.fence_done;
    assign hold_loads     = r.hold_loads;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_exec_path(nsf_path_e p);
        r.st == ST_EXEC && !dec.fence && dec.path == p;
    endsequence

    sequence s_evict_merge;
        s_exec_path(PATH_COMBINE) and (dec.evict && same_line);
    endsequence

    chk_misalign_fault: assert property (
        (r.st == ST_EXEC && r.req.op == OP_NT_STORE_PACKED_SINGLE && r.req.addr[3:0] != 4'h0)
        |=> nt_fault && !bus_wr.valid && !l1_upd.valid)
        else $error("misaligned packed store not faulted");

    chk_bus_stable: assert property (
        (bus_wr.valid && !bus_ack) |=> bus_wr.valid && $stable(bus_wr.addr) && $stable(bus_wr.be))
        else $error("bus write dropped before ack");

    chk_fence_drained: assert property (
        (fence_done && $past(r.req.op) != OP_LOAD_FENCE) |-> !buf_line.valid)
        else $error("store fence retired with pending line");

    chk_load_fence_free: assert property (
        (r.st == ST_FENCE && r.req.op == OP_LOAD_FENCE) |=> !bus_wr.valid)
        else $error("load fence drained stores");

    chk_uncached_direct: assert property (
        s_exec_path(PATH_UNCACHED) |=> bus_wr.valid && !r.drain && bus_wr.mtype == $past(r.req.mtype))
        else $error("uncached store not issued directly");

    chk_inplace_update: assert property (
        s_exec_path(PATH_IN_PLACE) |=> l1_upd.valid && !bus_wr.valid ##1 !l1_upd.valid)
        else $error("first-level hit not merged in place");

    chk_full_line: assert property (
        (r.st == ST_IDLE && buf_line.valid && &buf_line.be) |=> bus_wr.valid && &bus_wr.be && r.drain)
        else $error("full line not written as one transfer");

    chk_l2_evict: assert property (
        s_evict_merge |=> l2_evict_valid ##1 bus_wr.valid && bus_wr.addr == l2_evict_addr)
        else $error("second-level hit not written out");

    chk_fence_stall: assert property (
        (r.st == ST_FENCE) |-> !req_ready)
        else $error("later request accepted during fence");

    chk_first_type: assert property (
        (buf_merge && buf_line.valid) |=> buf_line.mtype == $past(buf_line.mtype))
        else $error("line type changed after first store");
endmodule : nsf_unit
`default_nettype wire

// File: verif/nsf_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Memory side of the system bus
// ----------------------------------------
module nsf_mem_model
    import nsf_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire nsf_line_s bus_wr,
    input  wire logic [2:0] lat,
    output logic           bus_ack
);
    logic [2:0] wait_r;

    // One write at a time; ack pulses once after lat+1 cycles of valid, so both prompt and slow memory occur
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
            wait_r  <= 3'h0;
        end else if (bus_ack || !bus_wr.valid) begin
            bus_ack <= 1'b0; // Data is visible to other agents only once acked
            wait_r  <= 3'h0;
        end else if (wait_r >= lat) begin
            bus_ack <= 1'b1;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
endmodule : nsf_mem_model
`default_nettype wire

// File: verif/nsf_unit_bench.sv
`include "nsf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module nsf_unit_bench;
    import nsf_pkg::*;
    typedef struct packed {
        logic [2:0]             kind;
        logic [LINE_ADDR_W-1:0] addr;
        logic [511:0]           data;
        logic [63:0]            be;
        nsf_mtype_e             mtype;
    } nsf_note_s;
    localparam logic [2:0] K_BUS = 3'h0, K_L1 = 3'h1, K_EVICT = 3'h2, K_FAULT = 3'h3, K_FENCE = 3'h4;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, sq_empty = 1'b1, lq_empty = 1'b1, gate_closed = 1'b0;
    logic req_ready, l2_evict_valid, nt_fault, fence_done, hold_loads, bus_ack;
    logic [2:0] ack_lat = 3'h0;
    logic [LINE_ADDR_W-1:0] l2_evict_addr;
    logic [33:0] ln;
    nsf_req_s  req = '0;
    nsf_line_s bus_wr, l1_upd;
    nsf_note_s notes[$];
    // Mirror of the one combining buffer
    logic wc_v = 1'b0;
    logic [LINE_ADDR_W-1:0] wc_a;
    logic [511:0] wc_d = '0;
    logic [63:0] wc_b = '0;
    nsf_mtype_e wc_mt;
    int failures = 0, checks_done = 0;

    nsf_unit dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .sq_empty(sq_empty), .lq_empty(lq_empty), .bus_wr(bus_wr), .bus_ack(bus_ack), .l1_upd(l1_upd),
        .l2_evict_valid(l2_evict_valid), .l2_evict_addr(l2_evict_addr), .nt_fault(nt_fault),
        .fence_done(fence_done), .hold_loads(hold_loads));
    nsf_mem_model mem (.clk(clk), .rst_n(rst_n), .bus_wr(bus_wr), .lat(ack_lat), .bus_ack(bus_ack));

    initial begin
        forever #5 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic nsf_note_s mk(logic [2:0] k, logic [LINE_ADDR_W-1:0] a, logic [511:0] d,
                                     logic [63:0] b, nsf_mtype_e m = MT_UNCACHEABLE);
        return '{kind: k, addr: a, data: d, be: b, mtype: m};
    endfunction : mk
    function automatic logic [511:0] bm(logic [63:0] b);
        for (int i = 0; i < 64; i++) bm[8*i+:8] = {8{b[i]}};
    endfunction : bm
    function automatic logic [127:0] rd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction : rd
    function automatic logic [39:0] at(logic [33:0] l, logic [1:0] c);
        return {l, c, 4'h0};
    endfunction : at
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic timeout;
        failures++;
        $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
        give_verdict();
    endtask : timeout
    task automatic chk(logic g, logic e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Oldest note against what appeared; data only counts where its byte is enabled
    task automatic observe(nsf_note_s g);
        nsf_note_s e;
        checks_done++;
        e = notes.size() != 0 ? notes.pop_front() : mk(3'h7, '0, '0, '0);
        g.data &= bm(g.be);
        e.data &= bm(e.be);
        if (e.kind != K_BUS) g.mtype = e.mtype;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : observe
    task automatic drain;
        if (wc_v) notes.push_back(mk(K_BUS, wc_a, wc_d, wc_b, wc_mt));
        wc_v = 1'b0;
    endtask : drain
    // Request held from a falling edge until the rising edge where ready is high
    task automatic drive(nsf_req_s r);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req = r;
        ack_lat = 3'($urandom % 6);
        n = 0;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 300) timeout();
        end
        @(negedge clk);
        req_valid = 1'b0;
    endtask : drive
    // Work out what the unit must emit, note it, then issue the request
    task automatic send(nsf_op_e op, nsf_mtype_e mt, logic [39:0] a, logic [127:0] d, logic [15:0] be,
                        logic [127:0] m, logic l1, logic l2);
        logic [15:0] eb;
        logic [LINE_ADDR_W-1:0] la;
        logic [63:0] lb;
        logic [511:0] ld;
        eb = be;
        if (op == OP_NT_MASKED_STORE) for (int i = 0; i < 16; i++) eb[i] = m[8*i+7];
        la = a[39:6];
        lb = 64'(eb) << (16 * a[5:4]);
        ld = 512'(d) << (128 * a[5:4]);
        if (op >= OP_STORE_FENCE) begin
            if (op != OP_LOAD_FENCE) drain();
            notes.push_back(mk(K_FENCE, '0, '0, '0));
        end else if (op == OP_NT_STORE_PACKED_SINGLE && a[3:0] != 4'h0) begin
            notes.push_back(mk(K_FAULT, '0, '0, '0));
        end else if (!(mt inside {MT_WRITE_COMBINING, MT_WRITE_THROUGH, MT_WRITE_BACK})) begin
            notes.push_back(mk(K_BUS, la, ld, lb, mt));
        end else if (l1) begin
            notes.push_back(mk(K_L1, la, ld, lb));
        end else begin
            if (l2) notes.push_back(mk(K_EVICT, la, '0, '0));
            if (wc_v && wc_a != la) drain();
            if (!wc_v) wc_mt = mt;
            if (!wc_v) wc_b = '0;
            wc_a = la;
            wc_v = 1'b1;
            wc_d = (wc_d & ~bm(lb)) | (ld & bm(lb));
            wc_b = wc_b | lb;
            if (l2 || &wc_b) drain();
        end
        drive('{op: op, mtype: mt, addr: a, data: d, be: be, mask: m, l1_hit: l1, l2_hit: l2});
    endtask : send
    task automatic watch(int n, logic rdy, logic hl);
        repeat (2) @(negedge clk);
        repeat (n) begin
            @(negedge clk);
            chk(req_ready, rdy);
            chk(hold_loads, hl);
        end
    endtask : watch
    task automatic settle(string s);
        int n;
        n = 0;
        while (notes.size() != 0 || req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 400) timeout();
        end
        $display("test %0s done", s);
    endtask : settle

    // Results seen at the falling edge, where registered outputs are settled
    always @(negedge clk) begin
        if (rst_n) begin
            if (bus_wr.valid && bus_ack) observe(mk(K_BUS, bus_wr.addr, bus_wr.data, bus_wr.be, bus_wr.mtype));
            if (l2_evict_valid) observe(mk(K_EVICT, l2_evict_addr, '0, '0));
            if (l1_upd.valid) observe(mk(K_L1, l1_upd.addr, l1_upd.data, l1_upd.be));
            if (nt_fault) observe(mk(K_FAULT, '0, '0, '0));
            if (fence_done) chk(gate_closed, 1'b0);
            if (fence_done) observe(mk(K_FENCE, '0, '0, '0));
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h208a));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        ln = 34'({$urandom, $urandom});
        send(OP_NT_STORE, MT_WRITE_BACK, at(ln, 2'h1), rd(), 16'hffff, '0, 0, 0);
        send(OP_NT_STORE, MT_WRITE_COMBINING, at(ln, 2'h1), rd(), 16'h00ff, '0, 0, 0);
        send(OP_NT_MASKED_STORE, MT_WRITE_BACK, at(ln, 2'h2), rd(), 16'hffff, rd(), 0, 0);
        sq_empty = 1'b0;
        lq_empty = 1'b0;
        gate_closed = 1'b1;
        send(OP_STORE_FENCE, MT_WRITE_BACK, '0, '0, '0, '0, 0, 0);
        watch(8, 1'b0, 1'b0);
        sq_empty = 1'b1;
        gate_closed = 1'b0;
        // Pending loads must not hold a store fence back
        settle("combine");
        lq_empty = 1'b1;
        ln = 34'({$urandom, $urandom});
        for (int c = 0; c < 4; c++) send(OP_NT_STORE, MT_WRITE_COMBINING, at(ln, 2'(c)), rd(), 16'hffff, '0, 0, 0);
        settle("full_line");
        ln = 34'({$urandom, $urandom});
        send(OP_NT_STORE, MT_WRITE_BACK, at(ln, 2'h0), rd(), 16'h0ff0, '0, 0, 0);
        send(OP_NT_STORE, MT_UNCACHEABLE, at(ln + 1, 2'h2), rd(), 16'($urandom) | 16'h1, '0, 0, 0);
        send(OP_NT_STORE, MT_WRITE_PROTECT, at(ln + 2, 2'h3), rd(), 16'hffff, '0, 0, 0);
        send(OP_NT_STORE_PACKED_SINGLE, MT_WRITE_BACK, at(ln, 2'h1) | 40'h8, rd(), 16'hffff, '0, 0, 0);
        send(OP_NT_STORE_PACKED_SINGLE, MT_WRITE_BACK, at(ln + 3, 2'h3), rd(), 16'hffff, '0, 0, 0);
        send(OP_STORE_FENCE, MT_WRITE_BACK, '0, '0, '0, '0, 0, 0);
        settle("uncached_fault");
        ln = 34'({$urandom, $urandom});
        send(OP_NT_STORE, MT_WRITE_BACK, at(ln, 2'h2), rd(), 16'hf00f, '0, 1, 0);
        send(OP_NT_STORE, MT_WRITE_THROUGH, at(ln + 1, 2'h1), rd(), 16'hffff, '0, 0, 1);
        settle("cache_hits");
        send(OP_NT_STORE, MT_WRITE_THROUGH, at(ln + 2, 2'h0), rd(), 16'hffff, '0, 0, 0);
        lq_empty = 1'b0;
        sq_empty = 1'b0;
        gate_closed = 1'b1;
        send(OP_LOAD_FENCE, MT_WRITE_BACK, '0, '0, '0, '0, 0, 0);
        watch(6, 1'b0, 1'b1);
        lq_empty = 1'b1;
        gate_closed = 1'b0;
        settle("load_fence");
        lq_empty = 1'b0;
        gate_closed = 1'b1;
        send(OP_FULL_FENCE, MT_WRITE_BACK, '0, '0, '0, '0, 0, 0);
        watch(4, 1'b0, 1'b1);
        lq_empty = 1'b1;
        watch(4, 1'b0, 1'b1);
        sq_empty = 1'b1;
        gate_closed = 1'b0;
        settle("full_fence");
        give_verdict();
    end
endmodule : nsf_unit_bench
`default_nettype wire
